// ===== design/dsbp_pkg.sv
// constants for the dma status and bus priority block
// assumes one 25 MHz clock and a plain register port with 8-bit data
// Notes on behaviour
// - writing one clears a recorded stop cause
// - pending flag stays until cleared or reset
// - two dummy states when bus returns to cpu
// - hold request beats dma request in byte mode
// - other requests sampled only in last cycle
// - later hold request still beats pending dma
// - mode b FD starts on timer four timeout
// - command bit one zero gives no software request
// - mode b 91 requests on conversion complete
package dsbp_pkg;
    localparam int NCH        = 4;
    localparam int AW         = 8;
    localparam int DW         = 8;
    localparam int NEVT       = 8;
    // register map: channel n at n*4, bus status at 0x10
    localparam logic [1:0] OFS_CMD    = 2'h0;
    localparam logic [1:0] OFS_MODEA  = 2'h1;
    localparam logic [1:0] OFS_MODEB  = 2'h2;
    localparam logic [1:0] OFS_STAT   = 2'h3;
    localparam logic [AW-1:0] ADR_BUS = 8'h10;
    localparam logic [AW-1:0] ADR_CHMAX = 8'h0F;
    // command fields
    localparam int CMD_EN   = 0;
    localparam int CMD_SWRQ = 1;
    // mode a fields
    localparam int MA_LV    = 6;
    localparam int MA_XM_LO = 0;
    localparam logic [1:0] XM_BYTE = 2'h0;
    // mode b fields
    localparam int MB_SEL_LO = 5;
    localparam int MB_INT    = 4;
    localparam int MB_UPD_LO = 0;
    localparam logic [DW-1:0] MB_TMR4_FIX_INC = 8'hFD;
    localparam logic [DW-1:0] MB_ADC_DONE     = 8'h91;
    // status fields
    localparam int ST_PEND = 0;
    localparam int ST_ERR  = 4;
    localparam int ST_TC   = 5;
    localparam int ST_MAT  = 6;
    localparam int ST_EOP  = 7;
    // reset values
    localparam logic [DW-1:0] RST_CMD   = 8'h00;
    localparam logic [DW-1:0] RST_MODEA = 8'h00;
    localparam logic [DW-1:0] RST_MODEB = 8'h00;
    // bus turnaround length in clock states
    localparam int DUMMY_STATES = 2;
    // grant word: channel and address update code
    localparam int GW = 6;
    typedef enum logic [3:0] {
        BUS_IDLE  = 4'b0001,
        BUS_DMA   = 4'b0010,
        BUS_DUMMY = 4'b0100,
        BUS_HOLD  = 4'b1000
    } dsbp_bus_t;
endpackage

// ===== design/dsbp_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous inputs; output changes once stages two and three agree
`timescale 1ns/10ps
module dsbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // pin side and synchronised side
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q_r  <= INIT;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign sync_out = q_r;
endmodule

// ===== design/dsbp_buf.sv
// two-entry buffer with valid and ready on both sides
// assumes producer and consumer share the clock
`timescale 1ns/10ps
module dsbp_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         srst_in,
    // fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // drain side
    output logic              out_valid_out,
    output logic      [W-1:0] out_data_out,
    input  wire logic         out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wp_r, rp_r, wp_nxt, rp_nxt;
    logic [PW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    always_comb begin
        push    = in_valid_in && (cnt_r != (PW+1)'(DEPTH));
        pop     = out_ready_in && (cnt_r != '0);
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    assign in_ready_out  = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rp_r];
endmodule

// ===== design/dsbp_top.sv
// status flags, request capture and bus priority for four dma channels
// assumes a transfer engine that drains grants and reports each done cycle
`timescale 1ns/10ps
module dsbp_top (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        srst_in,
    // register port
    input  wire logic [dsbp_pkg::AW-1:0]     reg_addr_in,
    input  wire logic [dsbp_pkg::DW-1:0]     reg_wdata_in,
    input  wire logic                        reg_wr_in,
    input  wire logic                        reg_rd_in,
    output logic      [dsbp_pkg::DW-1:0]     reg_rdata_out,
    // pins from outside, active low
    input  wire logic [dsbp_pkg::NCH-1:0]    transfer_request_input_n_in,
    input  wire logic                        bus_hold_request_n_in,
    output logic                             bus_hold_grant_n_out,
    // on-chip peripheral request sources
    input  wire logic [dsbp_pkg::NEVT-1:0]   periph_evt_in,
    // stop events per channel
    input  wire logic [dsbp_pkg::NCH-1:0]    external_end_evt_in,
    input  wire logic [dsbp_pkg::NCH-1:0]    match_evt_in,
    input  wire logic [dsbp_pkg::NCH-1:0]    tc_evt_in,
    input  wire logic [dsbp_pkg::NCH-1:0]    err_evt_in,
    // grants to the transfer engine
    output logic                             xfer_valid_out,
    output logic      [1:0]                  xfer_chan_out,
    output logic      [3:0]                  xfer_update_out,
    input  wire logic                        xfer_ready_in,
    input  wire logic                        xfer_done_in,
    input  wire logic                        xfer_last_in,
    // bus state
    output logic                             dummy_cycle_out,
    output logic                             dma_busy_out
);
    import dsbp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_chan(input logic [AW-1:0] a, input logic [1:0] ofs);
        is_chan = (a <= ADR_CHMAX) && (a[1:0] == ofs);
    endfunction

    function automatic logic [1:0] first_set(input logic [NCH-1:0] v);
        first_set = 2'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 2'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [NCH-1:0] transfer_request_input_n_s;
    logic           hold_n_s;

    dsbp_sync #(.W(NCH), .INIT('1)) u_sync_transfer_request_input (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .pin_in   (transfer_request_input_n_in),
        .sync_out (transfer_request_input_n_s)
    );

    dsbp_sync #(.W(1), .INIT(1'b1)) u_sync_hold (
        .clk_in   (clk_in),
        .srst_in  (srst_in),
        .pin_in   (bus_hold_request_n_in),
        .sync_out (hold_n_s)
    );

    logic hold_req;
    assign hold_req = !hold_n_s;

    ////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [DW-1:0] cmd_r   [NCH];
    logic [DW-1:0] modea_r [NCH];
    logic [DW-1:0] modeb_r [NCH];
    logic [DW-1:0] cmd_nxt [NCH];
    logic [DW-1:0] modea_nxt [NCH];
    logic [DW-1:0] modeb_nxt [NCH];
    logic [1:0]    wch;

    assign wch = reg_addr_in[3:2];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            cmd_nxt[c]   = cmd_r[c];
            modea_nxt[c] = modea_r[c];
            modeb_nxt[c] = modeb_r[c];
            if (reg_wr_in && wch == 2'(c)) begin
                if (is_chan(reg_addr_in, OFS_CMD)) begin
                    cmd_nxt[c] = reg_wdata_in;
                end
                if (is_chan(reg_addr_in, OFS_MODEA)) begin
                    modea_nxt[c] = reg_wdata_in;
                end
                if (is_chan(reg_addr_in, OFS_MODEB)) begin
                    modeb_nxt[c] = reg_wdata_in;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        for (int c = 0; c < NCH; c++) begin
            if (srst_in) begin
                cmd_r[c]   <= RST_CMD;
                modea_r[c] <= RST_MODEA;
                modeb_r[c] <= RST_MODEB;
            end else begin
                cmd_r[c]   <= cmd_nxt[c];
                modea_r[c] <= modea_nxt[c];
                modeb_r[c] <= modeb_nxt[c];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // request detection, pending and stop flags

    logic [NCH-1:0] src_lvl, src_prev_r, edge_w, lvl_req, req_w;
    logic [NCH-1:0] svc_r, svc_nxt, sw_r, sw_nxt, pend_r, pend_nxt;
    logic [NCH-1:0] eop_r, mat_r, tc_r, err_r;
    logic [NCH-1:0] eop_nxt, mat_nxt, tc_nxt, err_nxt;
    logic [NCH-1:0] grant_oh, stat_wr;
    logic [2:0]     sel [NCH];

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            sel[c] = modeb_r[c][MB_SEL_LO +: 3];
            // internal source picked by mode b, else the pin
            src_lvl[c] = modeb_r[c][MB_INT] ? periph_evt_in[sel[c]] : !transfer_request_input_n_s[c];
            edge_w[c]  = src_lvl[c] && !src_prev_r[c];
            lvl_req[c] = src_lvl[c] && !modea_r[c][MA_LV];
            stat_wr[c] = reg_wr_in && wch == 2'(c) && is_chan(reg_addr_in, OFS_STAT);
            // command bit one raises a software request, served only while command bit zero enables the channel
            sw_nxt[c]  = (sw_r[c] && !grant_oh[c])
                         || (reg_wr_in && wch == 2'(c) && is_chan(reg_addr_in, OFS_CMD)
                             && reg_wdata_in[CMD_SWRQ]);
            svc_nxt[c] = (svc_r[c] && !grant_oh[c])
                         || (edge_w[c] && modea_r[c][MA_LV]);
            req_w[c]   = cmd_r[c][CMD_EN] && (lvl_req[c] || svc_r[c] || sw_r[c]);
            // sticky, set wins over a write-one clear
            pend_nxt[c] = (pend_r[c] && !(stat_wr[c] && reg_wdata_in[ST_PEND]))
                          || (modea_r[c][MA_LV] ? edge_w[c] : src_lvl[c]);
            // write one clears a stop cause, a new event wins
            eop_nxt[c] = (eop_r[c] && !(stat_wr[c] && reg_wdata_in[ST_EOP]))
                         || external_end_evt_in[c];
            mat_nxt[c] = (mat_r[c] && !(stat_wr[c] && reg_wdata_in[ST_MAT]))
                         || match_evt_in[c];
            tc_nxt[c]  = (tc_r[c] && !(stat_wr[c] && reg_wdata_in[ST_TC]))
                         || tc_evt_in[c];
            err_nxt[c] = (err_r[c] && !(stat_wr[c] && reg_wdata_in[ST_ERR]))
                         || err_evt_in[c];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            // flags start clear
            src_prev_r <= '0;
            svc_r      <= '0;
            sw_r       <= '0;
            pend_r     <= '0;
            eop_r      <= '0;
            mat_r      <= '0;
            tc_r       <= '0;
            err_r      <= '0;
        end else begin
            src_prev_r <= src_lvl;
            svc_r      <= svc_nxt;
            sw_r       <= sw_nxt;
            pend_r     <= pend_nxt;
            eop_r      <= eop_nxt;
            mat_r      <= mat_nxt;
            tc_r       <= tc_nxt;
            err_r      <= err_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus ownership and priority

    dsbp_bus_t      st_r, st_nxt;
    logic [NCH-1:0] smp_r, smp_nxt;
    logic [1:0]     chan_r, chan_nxt;
    logic [1:0]     dcnt_r, dcnt_nxt;
    logic           hold_after_r, hold_after_nxt;
    logic           push, buf_rdy, sample_pt, last_cyc;
    logic [GW-1:0]  push_word;
    logic [1:0]     pick;

    assign last_cyc  = xfer_done_in && xfer_last_in;
    // other channels are looked at only when idle or in the last cycle
    assign sample_pt = (st_r == BUS_IDLE) || (st_r == BUS_DMA && last_cyc);
    assign pick      = first_set(req_w);

    always_comb begin
        st_nxt         = st_r;
        smp_nxt        = sample_pt ? req_w : smp_r;
        chan_nxt       = chan_r;
        dcnt_nxt       = dcnt_r;
        hold_after_nxt = hold_after_r;
        push           = 1'b0;
        grant_oh       = '0;
        unique case (st_r)
            BUS_IDLE: begin
                // hold wins a tie at the sampling point
                if (hold_req) begin
                    st_nxt = BUS_HOLD;
                end else if (|req_w && buf_rdy) begin
                    push         = 1'b1;
                    grant_oh[pick] = 1'b1;
                    chan_nxt     = pick;
                    st_nxt       = BUS_DMA;
                end
            end
            BUS_DMA: begin
                if (last_cyc) begin
                    // a later hold still beats a waiting channel
                    if (hold_req) begin
                        hold_after_nxt = 1'b1;
                        st_nxt         = BUS_DUMMY;
                        dcnt_nxt       = 2'(DUMMY_STATES - 1);
                    end else if (|req_w && buf_rdy) begin
                        push           = 1'b1;
                        grant_oh[pick] = 1'b1;
                        chan_nxt       = pick;
                    end else begin
                        hold_after_nxt = 1'b0;
                        st_nxt         = BUS_DUMMY;
                        dcnt_nxt       = 2'(DUMMY_STATES - 1);
                    end
                end
            end
            BUS_DUMMY: begin
                // turnaround of two states back to the cpu
                if (dcnt_r == 2'h0) begin
                    st_nxt = hold_after_r ? BUS_HOLD : BUS_IDLE;
                end else begin
                    dcnt_nxt = dcnt_r - 2'h1;
                end
            end
            BUS_HOLD: begin
                if (!hold_req) begin
                    st_nxt = BUS_IDLE;
                end
            end
            default: begin
                st_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_r         <= BUS_IDLE;
            smp_r        <= '0;
            chan_r       <= 2'h0;
            dcnt_r       <= 2'h0;
            hold_after_r <= 1'b0;
        end else begin
            st_r         <= st_nxt;
            smp_r        <= smp_nxt;
            chan_r       <= chan_nxt;
            dcnt_r       <= dcnt_nxt;
            hold_after_r <= hold_after_nxt;
        end
    end

    // grant carries channel and its address update code
    assign push_word = {pick, modeb_r[pick][MB_UPD_LO +: 4]};

    dsbp_buf #(.W(GW), .DEPTH(2)) u_buf (
        .clk_in        (clk_in),
        .srst_in       (srst_in),
        .in_valid_in   (push),
        .in_data_in    (push_word),
        .in_ready_out  (buf_rdy),
        .out_valid_out (xfer_valid_out),
        .out_data_out  ({xfer_chan_out, xfer_update_out}),
        .out_ready_in  (xfer_ready_in)
    );

    ////////////////////////////////////////////////////////////////////
    // read port and registered outputs

    logic [DW-1:0] rdata_r, rdata_nxt;
    logic          grant_n_r, dummy_r, busy_r;
    logic [1:0]    rch;

    assign rch = reg_addr_in[3:2];

    always_comb begin
        rdata_nxt = '0;
        if (reg_rd_in) begin
            if (reg_addr_in == ADR_BUS) begin
                rdata_nxt = {4'h0, chan_r, st_r == BUS_DMA, st_r == BUS_HOLD};
            end else if (is_chan(reg_addr_in, OFS_CMD)) begin
                rdata_nxt = cmd_r[rch];
            end else if (is_chan(reg_addr_in, OFS_MODEA)) begin
                rdata_nxt = modea_r[rch];
            end else if (is_chan(reg_addr_in, OFS_MODEB)) begin
                rdata_nxt = modeb_r[rch];
            end else if (is_chan(reg_addr_in, OFS_STAT)) begin
                rdata_nxt[ST_EOP]  = eop_r[rch];
                rdata_nxt[ST_MAT]  = mat_r[rch];
                rdata_nxt[ST_TC]   = tc_r[rch];
                rdata_nxt[ST_ERR]  = err_r[rch];
                rdata_nxt[ST_PEND] = pend_r[rch];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_r   <= '0;
            grant_n_r <= 1'b1;
            dummy_r   <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            rdata_r   <= rdata_nxt;
            grant_n_r <= !(st_nxt == BUS_HOLD);
            dummy_r   <= (st_nxt == BUS_DUMMY);
            busy_r    <= (st_nxt == BUS_DMA);
        end
    end

    assign reg_rdata_out        = rdata_r;
    assign bus_hold_grant_n_out = grant_n_r;
    assign dummy_cycle_out      = dummy_r;
    assign dma_busy_out         = busy_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_turnaround;
        (st_r == BUS_DUMMY) [*2] ##1 (st_r != BUS_DUMMY);
    endsequence

    property p_stop_clear;
        @(posedge clk_in) disable iff (srst_in)
        (stat_wr[0] && reg_wdata_in[ST_EOP] && !external_end_evt_in[0]) |=> !eop_r[0];
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("eop not cleared");

    property p_pend_hold;
        @(posedge clk_in) disable iff (srst_in)
        (pend_r[1] && !(stat_wr[1] && reg_wdata_in[ST_PEND])) |=> pend_r[1];
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending dropped");

    property p_dummy_len;
        @(posedge clk_in) disable iff (srst_in)
        (st_r == BUS_DMA && st_nxt == BUS_DUMMY) |=> s_turnaround;
    endproperty
    a_dummy_len: assert property (p_dummy_len) else $error("dummy not two states");

    property p_hold_tie;
        @(posedge clk_in) disable iff (srst_in)
        (st_r == BUS_IDLE && hold_req && |req_w) |=> (st_r == BUS_HOLD) && !bus_hold_grant_n_out;
    endproperty
    a_hold_tie: assert property (p_hold_tie) else $error("hold lost a tie");

    property p_sample_only_last;
        @(posedge clk_in) disable iff (srst_in)
        (st_r == BUS_DMA && !last_cyc) |-> !push ##1 $stable(smp_r);
    endproperty
    a_sample_only_last: assert property (p_sample_only_last) else $error("sampled early");

    property p_hold_late;
        @(posedge clk_in) disable iff (srst_in)
        (st_r == BUS_DMA && last_cyc && hold_req) |=> s_turnaround ##0 (st_r == BUS_HOLD);
    endproperty
    a_hold_late: assert property (p_hold_late) else $error("hold not served after dma");

    property p_tmr4;
        @(posedge clk_in) disable iff (srst_in)
        (modeb_r[2] == MB_TMR4_FIX_INC && modea_r[2][MA_LV] && periph_evt_in[7]
         && !src_prev_r[2] && !grant_oh[2]) |=> svc_r[2];
    endproperty
    a_tmr4: assert property (p_tmr4) else $error("timer request missed");

    property p_no_swrq;
        @(posedge clk_in) disable iff (srst_in)
        (reg_wr_in && is_chan(reg_addr_in, OFS_CMD) && wch == 2'h3 && !reg_wdata_in[CMD_SWRQ]
         && !sw_r[3]) |=> !sw_r[3];
    endproperty
    a_no_swrq: assert property (p_no_swrq) else $error("spurious software request");

    property p_adc;
        @(posedge clk_in) disable iff (srst_in)
        (modeb_r[0] == MB_ADC_DONE && !modea_r[0][MA_LV] && cmd_r[0][CMD_EN] && periph_evt_in[4])
        |-> req_w[0];
    endproperty
    a_adc: assert property (p_adc) else $error("conversion request missed");

    property p_reset_zero;
        @(posedge clk_in) srst_in |=> (pend_r == '0 && eop_r == '0 && mat_r == '0
                                       && tc_r == '0 && err_r == '0);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("flags not clear");
endmodule

// ===== testbench/dsbp_partner.sv
// far side model: transfer engine draining grants, external bus master
// assumes one clock shared with the block under test
`timescale 1ns/10ps
module dsbp_partner (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic srst_in,
    // grant stream and stall control
    input  wire logic xfer_valid_in,
    input  wire logic stall_in,
    output logic      xfer_ready_out,
    output logic      xfer_done_out,
    output logic      xfer_last_out,
    // external bus master
    input  wire logic hold_req_in,
    output logic      bus_hold_request_n_out
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    ////////////////////////////////////////////////////////////////
    // two transfer cycles per grant, the second one marked last
    always_comb begin
        cnt_nxt = (cnt_r == 2'h0) ? 2'h0 : cnt_r - 2'h1;
        if (xfer_valid_in && xfer_ready_out) begin
            cnt_nxt = 2'h3;
        end
    end
    always_ff @(posedge clk_in) begin
        cnt_r <= srst_in ? 2'h0 : cnt_nxt;
    end
    assign xfer_ready_out = !stall_in && (cnt_r == 2'h0);
    assign xfer_done_out = (cnt_r == 2'h2) || (cnt_r == 2'h1);
    assign xfer_last_out = (cnt_r == 2'h1);
    // pin is driven as the inverse of the hold request, so idle is high
    assign bus_hold_request_n_out = !hold_req_in;
endmodule

// ===== testbench/dsbp_top_test.sv
// register-call tests for the status and bus priority block
// assumes the partner model on the grant stream and hold pins
`timescale 1ns/10ps
module dsbp_top_test;
    import dsbp_pkg::*;
    logic clk_in = 0, srst_in = 1, wr = 0, rd = 0, stall = 0, hreq = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, evt = 8'h00;
    logic [3:0] req_n = 4'hF, upd;
    logic [15:0] stop_ev = 16'h0000;
    logic hold_n, grant_n, xv, ready, done, last, dummy, busy;
    logic [1:0] chan;
    int n_errors = 0, tests_run = 0, k;
    always #20 clk_in = ~clk_in;
    dsbp_top dsbp_top_inst (.clk_in(clk_in), .srst_in(srst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .transfer_request_input_n_in(req_n), .bus_hold_request_n_in(hold_n),
        .bus_hold_grant_n_out(grant_n), .periph_evt_in(evt),
        .external_end_evt_in(stop_ev[3:0]), .match_evt_in(stop_ev[7:4]),
        .tc_evt_in(stop_ev[11:8]), .err_evt_in(stop_ev[15:12]),
        .xfer_valid_out(xv), .xfer_chan_out(chan), .xfer_update_out(upd),
        .xfer_ready_in(ready), .xfer_done_in(done), .xfer_last_in(last),
        .dummy_cycle_out(dummy), .dma_busy_out(busy));
    dsbp_partner dsbp_partner_inst (.clk_in(clk_in), .srst_in(srst_in),
        .xfer_valid_in(xv), .stall_in(stall), .xfer_ready_out(ready),
        .xfer_done_out(done), .xfer_last_out(last), .hold_req_in(hreq),
        .bus_hold_request_n_out(hold_n));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic wait_sig(ref logic s, input logic v);
        k = 0;
        while (s !== v && k < 40) begin
            @(posedge clk_in);
            #1 k++;
        end
        if (s !== v) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, s, v);
        end
    endtask
    task automatic exp_grant(input logic [1:0] c, input logic [3:0] u);
        wait_sig(xv, 1'b1);
        chk({busy, xv, chan, upd}, {1'b1, 1'b1, c, u});
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk_in);
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rd_reg(8'(4 * c + 3), 8'h00);
            rd_reg(8'(4 * c + 2), RST_MODEB);
        end
        rd_reg(ADR_BUS, 8'h00);
        wr_reg(8'h20, 8'hFF);
        rd_reg(8'h20, 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_in);
            stop_ev <= 16'h0001 << (4 * i);
            @(posedge clk_in);
            stop_ev <= 16'h0000;
            rd_reg(8'h03, 8'h80 >> i);
            wr_reg(8'h03, 8'h80 >> i);
            rd_reg(8'h03, 8'h00);
        end
        wr_reg(8'h05, 8'h40);
        req_n <= 4'hD;
        repeat (8) @(posedge clk_in);
        req_n <= 4'hF;
        repeat (8) @(posedge clk_in);
        rd_reg(8'h07, 8'h01);
        rd_reg(8'h07, 8'h01);
        wr_reg(8'h07, 8'h01);
        rd_reg(8'h07, 8'h00);
        stall <= 1'b1;
        wr_reg(8'h00, 8'h01);
        repeat (10) @(posedge clk_in);
        #1 chk({7'h00, xv}, 8'h00);
        wr_reg(8'h00, 8'h03);
        exp_grant(2'h0, 4'h0);
        @(posedge clk_in);
        hreq <= 1'b1;
        wr_reg(8'h04, 8'h03);
        repeat (12) @(posedge clk_in);
        #1 chk({6'h00, grant_n, xv}, 8'h03);
        @(posedge clk_in);
        stall <= 1'b0;
        wait_sig(dummy, 1'b1);
        wait_sig(dummy, 1'b0);
        chk(8'(k), 8'(DUMMY_STATES));
        wait_sig(grant_n, 1'b0);
        chk({6'h00, grant_n, xv}, 8'h00);
        @(posedge clk_in);
        hreq <= 1'b0;
        exp_grant(2'h1, 4'h0);
        wait_sig(busy, 1'b0);
        wr_reg(8'h09, 8'h40);
        wr_reg(8'h0A, MB_TMR4_FIX_INC);
        wr_reg(8'h08, 8'h01);
        evt <= 8'h80;
        @(posedge clk_in);
        evt <= 8'h00;
        exp_grant(2'h2, 4'hD);
        wait_sig(busy, 1'b0);
        repeat (3) @(posedge clk_in);
        hreq <= 1'b1;
        req_n <= 4'hE;
        wait_sig(grant_n, 1'b0);
        chk({6'h00, grant_n, xv}, 8'h00);
        hreq <= 1'b0;
        req_n <= 4'hF;
        wait_sig(grant_n, 1'b1);
        wr_reg(8'h0D, 8'h00);
        wr_reg(8'h0E, MB_ADC_DONE);
        wr_reg(8'h0C, 8'h01);
        evt <= 8'h10;
        exp_grant(2'h3, 4'h1);
        evt <= 8'h00;
        wrap_up();
    end
endmodule
